// >>> logic/sfts_pkg.sv
// Purpose: Shared constants and types for the serial FIFO transmit flag and clock block
// Assumes: 200 MHz system clock, 8-bit characters
// Notes:   Data and count widths, the flag and clock idle reset values and the timing counts live here

package sfts_pkg;
   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [4:0] TX_FIFO_DEPTH = 5'h10;
   localparam int CNT_REG_W = 16;
   localparam int CNT_TX_LSB = 8;

   // ------------------------------------------------------------
   // Transmit trigger counts selected by the two select bits
   // ------------------------------------------------------------
   localparam logic [4:0] TX_TRIG_SEL0 = 5'h08;
   localparam logic [4:0] TX_TRIG_SEL1 = 5'h04;
   localparam logic [4:0] TX_TRIG_SEL2 = 5'h02;
   localparam logic [4:0] TX_TRIG_SEL3 = 5'h00;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic FLAG_RESET = 1'b1;
   localparam logic SCK_IDLE = 1'b1;

   // ------------------------------------------------------------
   // Timing: internal serial clock period, least 12 system cycles
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int SCK_PERIOD_NS = 60;
   localparam logic [3:0] SCK_HALF_CYC = 4'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
   localparam logic [3:0] CHAR_BITS = 4'h8;
   localparam logic [7:0] RX_BURST_PULSES = 8'h88;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SHIFT = 2'b10
   } sfts_tx_state_type;

   typedef enum logic [2:0] {
      CLR_IDLE = 3'b001,
      CLR_READ = 3'b010,
      CLR_ARMED = 3'b100
   } sfts_clr_state_type;
endpackage

// >>> logic/sfts_pipe_buf.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Same clock on both sides
// Notes:   Full throughput, a stall on the drain side fills both entries

`timescale 1ns/100ps

module sfts_pipe_buf
   import sfts_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [sfts_pkg::DATA_W-1:0] inData,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output logic [sfts_pkg::DATA_W-1:0] outData
);
   import sfts_pkg::*;

   logic [DATA_W-1:0] slot [2];
   logic [DATA_W-1:0] next_slot [2];
   logic [1:0] fill;
   logic [1:0] next_fill;
   logic rdIdx;
   logic next_rdIdx;
   logic push;
   logic pull;

   // Honest full and empty from the fill count
   assign inReady = (fill != 2'h2);
   assign outValid = (fill != 2'h0);
   assign outData = slot[rdIdx];
   assign push = inValid && inReady;
   assign pull = outValid && outReady;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_slot = slot;
      next_fill = fill;
      next_rdIdx = rdIdx;
      if (push) begin
         next_slot[rdIdx ^ fill[0]] = inData;
      end
      if (pull) begin
         next_rdIdx = ~rdIdx;
      end
      next_fill = 2'(fill + {1'b0, push} - {1'b0, pull});
   end

   // Register stage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slot[0] <= '0;
         slot[1] <= '0;
         fill <= 2'h0;
         rdIdx <= 1'b0;
      end else begin
         slot <= next_slot;
         fill <= next_fill;
         rdIdx <= next_rdIdx;
      end
   end
endmodule

// >>> logic/sfts_top.sv
// Purpose: Transmit FIFO, low flag, count report and serial clock drive
// Assumes: Receive path lives elsewhere and reports its count and trigger
// Notes:   Serial clock idles high, data changes on fall, peer samples on rise
//
// Contract
// - Flag sets when count drops to trigger
// - Power-on reset leaves flag set
// - Read one, write zero, overfill clears flag
// - Block transfer engine overfill also clears flag
// - Sixteen byte FIFO, room is sixteen minus trigger
// - Write into full FIFO is discarded
// - Transmit count in upper count byte
// - Trigger count from two select bits
// - Flag set means software may write
// - Receive-only internal clock runs while below trigger
// - Receive-only burst is 136 clock pulses

`timescale 1ns/100ps

module sfts_top
   import sfts_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Transmit FIFO write port
   input wire logic wrValid,
   input wire logic [sfts_pkg::DATA_W-1:0] wrData,
   input wire logic wrFromDma,
   output logic wrDrop,
   // Status flag access
   input wire logic flagRead,
   input wire logic flagWrite0,
   output logic txFifoLowFlag,
   // Control bits
   input wire logic txEnable,
   input wire logic rxEnable,
   input wire logic intClkSel,
   input wire logic txTrigSelHi,
   input wire logic txTrigSelLo,
   // Receive FIFO status
   input wire logic [sfts_pkg::CNT_W-1:0] rxFifoCount,
   input wire logic [sfts_pkg::CNT_W-1:0] rxTrigCount,
   // Count report
   output logic [sfts_pkg::CNT_REG_W-1:0] fifoCountReg,
   // Serial pins
   input wire logic sckIn,
   output logic sckOut,
   output logic sckOe_n,
   output logic txdOut
);
   import sfts_pkg::*;

   // ------------------------------------------------------------
   // Transmit FIFO and flag
   // ------------------------------------------------------------
   logic [DATA_W-1:0] mem [16], next_mem [16];
   logic [PTR_W-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
   logic [CNT_W-1:0] txCount, next_txCount, trig;
   logic next_txFifoLowFlag, next_wrDrop, wrAccept, pop, setEv, clrEv;
   logic [CNT_REG_W-1:0] next_fifoCountReg;
   sfts_clr_state_type clrState, next_clrState;
   logic bufInReady, bufOutValid, bufOutReady;
   logic [DATA_W-1:0] bufOutData;

   // Trigger decode from the select bits
   always_comb begin
      case ({txTrigSelHi, txTrigSelLo})
         2'b00: trig = TX_TRIG_SEL0;
         2'b01: trig = TX_TRIG_SEL1;
         2'b10: trig = TX_TRIG_SEL2;
         default: trig = TX_TRIG_SEL3;
      endcase
   end

   // Full is judged before the same-cycle move, so a write never races a pop
   assign wrAccept = wrValid && (txCount < TX_FIFO_DEPTH);
   assign pop = (txCount != 5'h00) && bufInReady;

   // FIFO pointers, count, flag and clear sequence
   always_comb begin
      next_mem = mem;
      next_wrPtr = wrPtr;
      next_rdPtr = rdPtr;
      if (wrAccept) begin
         next_mem[wrPtr] = wrData;
         next_wrPtr = 4'(wrPtr + 4'h1);
      end
      if (pop) begin
         next_rdPtr = 4'(rdPtr + 4'h1);
      end
      next_txCount = 5'(txCount + {4'h0, wrAccept} - {4'h0, pop});
      next_wrDrop = wrValid && !wrAccept;
      setEv = pop && (next_txCount <= trig);
      clrEv = wrAccept && (next_txCount > trig)
         && (wrFromDma || clrState == CLR_ARMED);
      next_clrState = clrState;
      case (clrState)
         CLR_IDLE: begin
            if (flagRead && txFifoLowFlag) next_clrState = CLR_READ;
         end
         CLR_READ: begin
            if (flagWrite0) next_clrState = CLR_ARMED;
         end
         CLR_ARMED: begin
            if (clrEv) next_clrState = CLR_IDLE;
         end
         default: next_clrState = CLR_IDLE;
      endcase
      // A set in the same cycle beats any clear
      if (setEv) begin
         next_txFifoLowFlag = 1'b1;
         next_clrState = CLR_IDLE;
      end else if (clrEv) begin
         next_txFifoLowFlag = 1'b0;
      end else begin
         next_txFifoLowFlag = txFifoLowFlag;
      end
      next_fifoCountReg = {3'h0, next_txCount, 3'h0, rxFifoCount};
   end

   // FIFO register stage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 16; i++) mem[i] <= '0;
         wrPtr <= '0;
         rdPtr <= '0;
         txCount <= '0;
         wrDrop <= 1'b0;
         txFifoLowFlag <= FLAG_RESET;
         clrState <= CLR_IDLE;
         fifoCountReg <= '0;
      end else begin
         mem <= next_mem;
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         txCount <= next_txCount;
         wrDrop <= next_wrDrop;
         txFifoLowFlag <= next_txFifoLowFlag;
         clrState <= next_clrState;
         fifoCountReg <= next_fifoCountReg;
      end
   end

   // Buffer between FIFO head and shift register absorbs loader stalls
   sfts_pipe_buf u_buf (.clk_sys(clk_sys), .rst_n(rst_n), .inValid(txCount != 5'h00),
      .inReady(bufInReady), .inData(mem[rdPtr]), .outValid(bufOutValid),
      .outReady(bufOutReady), .outData(bufOutData));

   // ------------------------------------------------------------
   // Serial clock and shift register
   // ------------------------------------------------------------
   sfts_tx_state_type txState, next_txState;
   logic [DATA_W-1:0] shiftReg, next_shiftReg;
   logic [3:0] bitsLeft, next_bitsLeft, divCnt, next_divCnt;
   logic [7:0] pulsesLeft, next_pulsesLeft;
   logic burstDone, next_burstDone, next_sckOut, next_sckOe_n, next_txdOut;
   logic sck1, sck2, sck3, sckLvl, next_sckLvl, rxCond, clkRun, tick, riseEv, fallEv;

   // Receive-only internal clock while the receive FIFO is below trigger
   assign rxCond = rxEnable && !txEnable && intClkSel && (rxFifoCount < rxTrigCount);
   assign clkRun = (txState == TX_SHIFT) || (pulsesLeft != 8'h00);
   assign tick = intClkSel && clkRun && (divCnt == 4'(SCK_HALF_CYC - 4'h1));
   assign bufOutReady = (txState == TX_IDLE) && txEnable;

   // Edges come from the divider or from the filtered external clock
   always_comb begin
      next_sckLvl = (sck2 == sck3) ? sck3 : sckLvl;
      if (intClkSel) begin
         riseEv = tick && !sckOut;
         fallEv = tick && sckOut;
      end else begin
         riseEv = (sck2 == sck3) && sck3 && !sckLvl;
         fallEv = (sck2 == sck3) && !sck3 && sckLvl;
      end
   end

   // Divider, burst count and transmit shifting
   always_comb begin
      next_divCnt = tick ? 4'h0 : (intClkSel && clkRun ? 4'(divCnt + 4'h1) : 4'h0);
      next_sckOut = (intClkSel && clkRun) ? (tick ? !sckOut : sckOut) : SCK_IDLE;
      next_sckOe_n = !intClkSel;
      next_pulsesLeft = pulsesLeft;
      next_burstDone = burstDone;
      if (!rxCond) begin
         next_pulsesLeft = 8'h00;
         next_burstDone = 1'b0;
      end else if (!burstDone) begin
         next_pulsesLeft = RX_BURST_PULSES;
         next_burstDone = 1'b1;
      end else if (riseEv && pulsesLeft != 8'h00) begin
         next_pulsesLeft = 8'(pulsesLeft - 8'h01);
      end
      next_txState = txState;
      next_shiftReg = shiftReg;
      next_bitsLeft = bitsLeft;
      next_txdOut = txdOut;
      case (txState)
         TX_IDLE: begin
            if (bufOutValid && bufOutReady) begin
               next_shiftReg = bufOutData;
               next_txdOut = bufOutData[0];
               next_bitsLeft = CHAR_BITS;
               next_txState = TX_SHIFT;
            end
         end
         TX_SHIFT: begin
            if (riseEv) begin
               next_bitsLeft = 4'(bitsLeft - 4'h1);
               if (bitsLeft == 4'h1) next_txState = TX_IDLE;
            end else if (fallEv && bitsLeft < CHAR_BITS) begin
               next_shiftReg = {1'b0, shiftReg[DATA_W-1:1]};
               next_txdOut = shiftReg[1];
            end
         end
         default: next_txState = TX_IDLE;
      endcase
   end

   // Serial register stage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sck1 <= SCK_IDLE;
         sck2 <= SCK_IDLE;
         sck3 <= SCK_IDLE;
         sckLvl <= SCK_IDLE;
         txState <= TX_IDLE;
         shiftReg <= '0;
         bitsLeft <= '0;
         divCnt <= '0;
         pulsesLeft <= '0;
         burstDone <= 1'b0;
         sckOut <= SCK_IDLE;
         sckOe_n <= 1'b1;
         txdOut <= 1'b1;
      end else begin
         sck1 <= sckIn;
         sck2 <= sck1;
         sck3 <= sck2;
         sckLvl <= next_sckLvl;
         txState <= next_txState;
         shiftReg <= next_shiftReg;
         bitsLeft <= next_bitsLeft;
         divCnt <= next_divCnt;
         pulsesLeft <= next_pulsesLeft;
         burstDone <= next_burstDone;
         sckOut <= next_sckOut;
         sckOe_n <= next_sckOe_n;
         txdOut <= next_txdOut;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_flag_set;
      (pop && !wrAccept && (txCount - 5'h01) <= trig) |=> txFifoLowFlag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set at trigger");
   property p_flag_fall;
      $fell(txFifoLowFlag) |-> $past(wrAccept)
         && ($past(wrFromDma) || $past(clrState) == CLR_ARMED);
   endproperty
   a_flag_fall: assert property (p_flag_fall) else $error("flag cleared without cause");
   property p_dma_clear;
      (wrAccept && wrFromDma && !pop && txCount >= trig) |=> !txFifoLowFlag;
   endproperty
   a_dma_clear: assert property (p_dma_clear) else $error("engine write kept flag");
   property p_depth;
      txCount <= TX_FIFO_DEPTH;
   endproperty
   a_depth: assert property (p_depth) else $error("fifo count above depth");
   property p_discard;
      (wrValid && txCount == TX_FIFO_DEPTH && !pop) |=> ($stable(txCount) && wrDrop);
   endproperty
   a_discard: assert property (p_discard) else $error("full write not discarded");
   property p_count_report;
      fifoCountReg[CNT_REG_W-1:CNT_TX_LSB] == {3'h0, txCount};
   endproperty
   a_count_report: assert property (p_count_report) else $error("count report mismatch");
   property p_count_step;
      ##1 txCount == 5'($past(txCount) + $past(wrAccept) - $past(pop));
   endproperty
   a_count_step: assert property (p_count_step) else $error("count step wrong");
   property p_rx_clock_stop;
      (!rxCond && txState == TX_IDLE) |=> (pulsesLeft == 8'h00);
   endproperty
   a_rx_clock_stop: assert property (p_rx_clock_stop) else $error("clock off condition");
   property p_burst_len;
      ($rose(burstDone) && rxCond) |-> pulsesLeft == RX_BURST_PULSES;
   endproperty
   a_burst_len: assert property (p_burst_len) else $error("burst length wrong");
endmodule

// >>> tb/sfts_serial_peer.sv
// Purpose: Serial peer on the far side of the port, follows or makes the clock
// Assumes: Bits sampled on the clock rise, LSB first, 8 bits a character
// Notes:   External clock idles high and only runs inside a frame

`timescale 1ns/100ps

module sfts_serial_peer (
   // Reset
   input wire logic rst_n,
   // Serial pins
   input wire logic sckOut,
   input wire logic sckOe_n,
   input wire logic txdOut,
   output logic sckIn
);
   logic [7:0] rxMem [0:127];
   logic [7:0] shiftReg;
   logic lineClk;
   int bitCnt;
   int byteCnt;
   int riseCnt;

   // Whoever drives the pin owns the clock
   assign lineClk = sckOe_n ? sckIn : sckOut;

   initial sckIn = 1'b1;

   // Exact pulse count so the character count is known
   task automatic ext_clocks(input int n);
      repeat (n) begin
         #40 sckIn = 1'b0;
         #40 sckIn = 1'b1;
      end
   endtask

   // Drop a partial character left by a cut burst
   task automatic realign();
      bitCnt = 0;
   endtask

   // Sample on each rise, assemble LSB first
   always @(posedge lineClk or negedge rst_n) begin
      if (!rst_n) begin
         bitCnt = 0;
         byteCnt = 0;
         riseCnt = 0;
      end else begin
         riseCnt++;
         shiftReg = {txdOut, shiftReg[7:1]};
         bitCnt++;
         if (bitCnt == 8) begin
            rxMem[byteCnt] = shiftReg;
            byteCnt++;
            bitCnt = 0;
         end
      end
   end
endmodule

// >>> tb/sfts_top_tb.sv
// Purpose: Self-checking bench for the transmit FIFO, low flag and serial clock
// Assumes: Inputs change on the falling edge, outputs read there
// Notes:   Each scenario waits out the serial line before the next one starts

`timescale 1ns/100ps

module sfts_top_tb;
   import sfts_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic wrValid = 1'b0;
   logic [DATA_W-1:0] wrData = 8'h00;
   logic wrFromDma = 1'b0;
   logic flagRead = 1'b0;
   logic flagWrite0 = 1'b0;
   logic txEnable = 1'b0;
   logic rxEnable = 1'b0;
   logic intClkSel = 1'b1;
   logic txTrigSelHi = 1'b0;
   logic txTrigSelLo = 1'b0;
   logic [CNT_W-1:0] rxFifoCount = 5'h00;
   logic [CNT_W-1:0] rxTrigCount = 5'h00;
   logic sckIn, wrDrop, txFifoLowFlag, sckOut, sckOe_n, txdOut;
   logic [CNT_REG_W-1:0] fifoCountReg;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;

   // 200 MHz system clock
   always #2.5 clk_sys = ~clk_sys;

   sfts_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wrValid(wrValid), .wrData(wrData),
      .wrFromDma(wrFromDma), .wrDrop(wrDrop), .flagRead(flagRead), .flagWrite0(flagWrite0),
      .txFifoLowFlag(txFifoLowFlag), .txEnable(txEnable), .rxEnable(rxEnable),
      .intClkSel(intClkSel), .txTrigSelHi(txTrigSelHi), .txTrigSelLo(txTrigSelLo),
      .rxFifoCount(rxFifoCount), .rxTrigCount(rxTrigCount), .fifoCountReg(fifoCountReg),
      .sckIn(sckIn), .sckOut(sckOut), .sckOe_n(sckOe_n), .txdOut(txdOut));

   sfts_serial_peer i_peer (.rst_n(rst_n), .sckOut(sckOut), .sckOe_n(sckOe_n),
      .txdOut(txdOut), .sckIn(sckIn));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // One byte, drop pulse read in the cycle after the taking edge
   task automatic wr(input logic [7:0] d, input logic dma, output logic drop);
      @(negedge clk_sys);
      wrValid = 1'b1;
      wrData = d;
      wrFromDma = dma;
      @(negedge clk_sys);
      drop = wrDrop;
      wrValid = 1'b0;
      wrFromDma = 1'b0;
   endtask

   task automatic pulse(input logic rd);
      @(negedge clk_sys);
      flagRead = rd;
      flagWrite0 = !rd;
      @(negedge clk_sys);
      flagRead = 1'b0;
      flagWrite0 = 1'b0;
   endtask

   task automatic wait_bytes(input int n);
      int k;
      k = 0;
      while (i_peer.byteCnt < n && k < 4000) begin
         tick(1);
         k++;
      end
      chk("peer bytes", 16'(i_peer.byteCnt), 16'(n));
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Software clear sequence, overfill, then drain with trigger 4
   task automatic t_clear();
      logic d;
      int b;
      int k;
      b = i_peer.byteCnt;
      txTrigSelLo = 1'b1;
      for (int i = 0; i < 18; i++) begin
         if (i == 2) pulse(1'b0);
         if (i == 7) begin
            chk("flag", 16'(txFifoLowFlag), 16'h0001); // Lone write0 ignored
            pulse(1'b1);
            pulse(1'b0);
         end
         wr(8'(8'h30 + i), 1'b0, d);
         chk("drop", 16'(d), 16'h0000); // Room left
         if (i == 7) chk("flag", 16'(txFifoLowFlag), 16'h0000); // Full sequence
      end
      tick(2);
      chk("count", {8'h00, fifoCountReg[15:8]}, 16'h0010); // Upper byte
      wr(8'hEE, 1'b0, d);
      chk("drop", 16'(d), 16'h0001); // Extra byte lost
      chk("count", {8'h00, fifoCountReg[15:8]}, 16'h0010); // Unchanged
      txEnable = 1'b1;
      k = 0;
      while (txFifoLowFlag !== 1'b1 && k < 3000) begin
         tick(1);
         k++;
      end
      chk("count at set", {8'h00, fifoCountReg[15:8]}, 16'h0004); // Set at trigger
      wait_bytes(b + 18);
      for (int i = 0; i < 18; i++) chk("byte", 16'(i_peer.rxMem[b + i]), 16'(8'h30 + i));
      chk("count", {8'h00, fifoCountReg[15:8]}, 16'h0000); // Drained
   endtask

   // Engine writes against every trigger select code
   task automatic t_trig();
      logic [4:0] trig [4] = '{TX_TRIG_SEL0, TX_TRIG_SEL1, TX_TRIG_SEL2, TX_TRIG_SEL3};
      logic d;
      int b;
      for (int s = 0; s < 4; s++) begin
         b = i_peer.byteCnt;
         txEnable = 1'b0;
         {txTrigSelHi, txTrigSelLo} = 2'(s);
         wr(8'h11, 1'b1, d);
         wr(8'h22, 1'b1, d);
         tick(4);
         for (int i = 0; i < trig[s]; i++) wr(8'(i), 1'b1, d);
         chk("flag", 16'(txFifoLowFlag), 16'h0001); // At trigger stays set
         wr(8'h5A, 1'b1, d);
         chk("flag", 16'(txFifoLowFlag), 16'h0000); // Above trigger clears
         txEnable = 1'b1;
         wait_bytes(b + trig[s] + 3);
         tick(20);
         chk("flag", 16'(txFifoLowFlag), 16'h0001); // Set again by draining
      end
   endtask

   // Receive-only burst on the internal clock
   task automatic t_rx();
      int r;
      int r2;
      txEnable = 1'b0;
      rxEnable = 1'b1;
      rxTrigCount = 5'h01;
      rxFifoCount = 5'h00;
      r = i_peer.riseCnt;
      tick(2000);
      chk("burst rises", 16'(i_peer.riseCnt - r), {8'h00, RX_BURST_PULSES});
      chk("oe", 16'(sckOe_n), 16'h0000); // Device drives clock
      rxFifoCount = 5'h01;
      tick(40);
      chk("rx count", {8'h00, fifoCountReg[7:0]}, 16'h0001); // Lower byte
      rxFifoCount = 5'h00;
      r = i_peer.riseCnt;
      tick(120);
      rxFifoCount = 5'h01;
      tick(3);
      r2 = i_peer.riseCnt;
      tick(60);
      chk("restart", 16'(r2 > r), 16'h0001); // Burst resumes
      chk("stop", 16'(i_peer.riseCnt - r2), 16'h0000); // Stops at once
      rxEnable = 1'b0;
   endtask

   // Internal clock with both enables: one dummy byte per wanted character
   task automatic t_dummy();
      logic d;
      int r;
      rxEnable = 1'b1;
      txEnable = 1'b1;
      rxTrigCount = 5'h01;
      rxFifoCount = 5'h00;
      tick(20);
      r = i_peer.riseCnt;
      wr(8'hA5, 1'b0, d);
      wr(8'h5A, 1'b0, d);
      tick(400);
      chk("dummy rises", 16'(i_peer.riseCnt - r), 16'h0010); // Two characters only
      rxEnable = 1'b0;
   endtask

   // One character on the peer's own clock
   task automatic t_ext();
      logic d;
      int b;
      intClkSel = 1'b0;
      txEnable = 1'b1;
      tick(3);
      chk("oe", 16'(sckOe_n), 16'h0001); // Pin released
      i_peer.realign();
      b = i_peer.byteCnt;
      wr(8'hC5, 1'b0, d);
      tick(10);
      i_peer.ext_clocks(8);
      tick(10);
      chk("ext byte", 16'(i_peer.rxMem[b]), 16'h00C5); // Clocked by peer
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   // Main sequence
   initial begin
      tick(5);
      rst_n = 1'b1;
      tick(2);
      chk("flag", 16'(txFifoLowFlag), 16'h0001); // Power-on value
      chk("count", fifoCountReg, 16'h0000); // Empty after reset
      t_clear();
      t_trig();
      t_rx();
      t_dummy();
      t_ext();
      stop_test();
   end
endmodule
